// ---- rtl/scc_core.sv ----
`timescale 1ns/1ns
module scc_core (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic CE_I,
  // Configuration
  input wire scc_pkg::scc_cfg_t CFG_I,
  // Clock sources
  input wire logic BRG_TICK_I,
  input wire logic TIMER_MATCH_I,
  // Transmit write port
  input wire logic TX_VALID_I,
  output logic TX_READY_O,
  input wire logic [7:0] TX_DATA_I,
  input wire logic TX_NINTH_I,
  // Receive read port
  output logic RX_VALID_O,
  input wire logic RX_READY_I,
  output scc_pkg::scc_word_t RX_WORD_O,
  input wire logic FLAGS_READ_I,
  output logic PARITY_FAULT_FLAG_O,
  output logic OVERRUN_FLAG_O,
  output logic FRAMING_FLAG_O,
  // Events
  output logic RECEIVE_IRQ_O,
  output logic TRANSMIT_IRQ_O,
  // Pins
  input wire logic SERIAL_IN_PIN_I,
  output logic SERIAL_OUT_PIN_O,
  input wire logic CTS_N_I,
  input wire logic SHIFT_CLOCK_PIN_I,
  output logic SHIFT_CLOCK_PIN_O,
  output logic SHIFT_CLOCK_PIN_OE_O
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction
  function automatic logic par7(input logic [6:0] d, input logic even);
    return (^d) ^ ~even;
  endfunction
  // Bits between start and stop: data plus parity or ninth bit
  function automatic logic [3:0] frame_bits(input logic [1:0] m, input logic pe);
    if (m == scc_pkg::MODE_U9) begin
      return 4'h9;
    end
    return (m == scc_pkg::MODE_U7 ? 4'h7 : 4'h8) + {3'h0, pe};
  endfunction

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_ARM = 4'h2,
    TX_SEND = 4'h4,
    TX_HOLD = 4'h8
  } scc_tx_st_t;

  // ****************************************
  // Base clock
  // ****************************************
  logic is_uart;
  logic sck_d_ff, nxt_sck_d;
  logic half_ff, nxt_half;
  logic base;
  logic sync_edge;
  logic sck_rise, sck_fall;
  assign is_uart = CFG_I.mode != scc_pkg::MODE_SYNC;
  assign sck_rise = SHIFT_CLOCK_PIN_I & ~sck_d_ff;
  assign sck_fall = ~SHIFT_CLOCK_PIN_I & sck_d_ff;
  always_comb begin
    nxt_sck_d = SHIFT_CLOCK_PIN_I;
    nxt_half = half_ff;
    if (!CFG_I.clk_dir_in && BRG_TICK_I) begin
      nxt_half = ~half_ff;
    end
    base = 1'b0;
    unique case (CFG_I.clk_src)
      scc_pkg::SRC_TIMER: base = TIMER_MATCH_I;
      scc_pkg::SRC_BRG: base = BRG_TICK_I;
      scc_pkg::SRC_SYS: base = 1'b1;
      scc_pkg::SRC_PIN: base = sck_rise;
    endcase
    // Own clock: shift on the selected half_ff toggle; input clock: selected edge
    if (CFG_I.clk_dir_in) begin
      sync_edge = CFG_I.edge_fall ? sck_fall : sck_rise;
    end else begin
      sync_edge = BRG_TICK_I & (CFG_I.edge_fall ? half_ff : ~half_ff);
    end
  end

  // ****************************************
  // Transmit path
  // ****************************************
  logic [3:0] txc_ff, nxt_txc;
  logic tick;
  scc_tx_st_t tst_ff, nxt_tst;
  logic [9:0] tsh_ff, nxt_tsh;
  logic [3:0] tbits_ff, nxt_tbits;
  logic tout_ff, nxt_tout;
  logic tirq_ff, nxt_tirq;
  logic tbusy;
  logic tninth;
  logic [7:0] tdata;
  assign tick = base && txc_ff == scc_pkg::TICK_LAST;
  // One-hot code: bit 0 is the idle state flip-flop itself
  assign TX_READY_O = tst_ff[0];
  always_comb begin
    tdata = TX_DATA_I;
    tninth = TX_NINTH_I;
    if (CFG_I.parity_en && CFG_I.mode == scc_pkg::MODE_U7) begin
      tdata[7] = par7(TX_DATA_I[6:0], CFG_I.parity_even);
    end
    if (CFG_I.parity_en && CFG_I.mode == scc_pkg::MODE_U8) begin
      tninth = ~((^TX_DATA_I) ^ CFG_I.parity_even);
    end
    nxt_txc = base && is_uart ? txc_ff + 4'h1 : txc_ff;
    nxt_tst = tst_ff;
    nxt_tsh = tsh_ff;
    nxt_tbits = tbits_ff;
    nxt_tout = tout_ff;
    nxt_tirq = 1'b0;
    unique case (tst_ff)
      TX_IDLE: begin
        if (TX_VALID_I) begin
          nxt_tsh = {1'b0, tninth, tdata};
          nxt_tbits = is_uart ? frame_bits(CFG_I.mode, CFG_I.parity_en) : scc_pkg::SYNC_BITS;
          nxt_tst = TX_ARM;
        end
      end
      TX_ARM: begin
        if (CFG_I.handshake_en && CTS_N_I) begin
          nxt_tst = TX_HOLD;
        end else if (!is_uart) begin
          nxt_tst = TX_SEND;
        end else if (tick) begin
          nxt_tout = 1'b0;
          nxt_tst = TX_SEND;
        end
      end
      TX_HOLD: begin
        if (!CTS_N_I && tick) begin
          nxt_tout = 1'b0;
          nxt_tst = TX_SEND;
        end
      end
      TX_SEND: begin
        if (is_uart ? tick : sync_edge) begin
          if (tbits_ff == 4'h0) begin
            nxt_tout = 1'b1;
            nxt_tirq = 1'b1;
            nxt_tst = TX_IDLE;
          end else begin
            nxt_tout = tsh_ff[0];
            nxt_tsh = {1'b1, tsh_ff[9:1]};
            nxt_tbits = tbits_ff - 4'h1;
          end
        end
      end
      default: nxt_tst = TX_IDLE;
    endcase
  end

  // ****************************************
  // Receive path
  // ****************************************
  logic [3:0] rxc_ff, nxt_rxc;
  logic [2:0] smp_ff, nxt_smp;
  logic ract_ff, nxt_ract;
  logic [3:0] ridx_ff, nxt_ridx;
  logic [8:0] rsh_ff, nxt_rsh;
  logic [3:0] rlast;
  logic bitv;
  logic push;
  scc_pkg::scc_word_t pword;
  logic pe_ff, nxt_pe, oe_ff, nxt_oe, fe_ff, nxt_fe, rirq_ff, nxt_rirq;
  scc_pkg::scc_word_t buf_ff [2];
  scc_pkg::scc_word_t nxt_buf [2];
  logic [1:0] cnt_ff, nxt_cnt;
  logic pop;
  logic ninth_mode;
  assign ninth_mode = CFG_I.mode == scc_pkg::MODE_U9 ||
    (CFG_I.mode == scc_pkg::MODE_U8 && CFG_I.parity_en);
  assign bitv = maj3({smp_ff[1:0], SERIAL_IN_PIN_I});
  assign pop = RX_READY_I && cnt_ff != 2'h0;
  always_comb begin
    rlast = frame_bits(CFG_I.mode, CFG_I.parity_en);
    nxt_rxc = rxc_ff;
    nxt_smp = smp_ff;
    nxt_ract = ract_ff;
    nxt_ridx = ridx_ff;
    nxt_rsh = rsh_ff;
    nxt_pe = pe_ff;
    nxt_oe = oe_ff;
    nxt_fe = fe_ff;
    if (FLAGS_READ_I) begin
      nxt_pe = 1'b0;
      nxt_oe = 1'b0;
      nxt_fe = 1'b0;
    end
    nxt_rirq = 1'b0;
    push = 1'b0;
    pword = '{data: rsh_ff[7:0], ninth: rsh_ff[8]};
    if (!CFG_I.receive_en) begin
      nxt_ract = 1'b0;
      nxt_rxc = 4'h0;
    end else if (!is_uart) begin
      if (sync_edge) begin
        nxt_rsh = {1'b0, SERIAL_IN_PIN_I, rsh_ff[7:1]};
        nxt_ridx = ridx_ff + 4'h1;
        if (ridx_ff == scc_pkg::SYNC_BITS - 4'h1) begin
          nxt_ridx = 4'h0;
          push = 1'b1;
          pword = '{data: {SERIAL_IN_PIN_I, rsh_ff[7:1]}, ninth: 1'b0};
        end
      end
    end else if (base) begin
      nxt_rxc = rxc_ff + 4'h1;
      if (!ract_ff && SERIAL_IN_PIN_I && rxc_ff < scc_pkg::SAMPLE_FIRST) begin
        nxt_rxc = 4'h0;
      end
      if (rxc_ff >= scc_pkg::SAMPLE_FIRST && rxc_ff <= scc_pkg::SAMPLE_LAST) begin
        nxt_smp = {smp_ff[1:0], SERIAL_IN_PIN_I};
      end
      if (rxc_ff == scc_pkg::SAMPLE_LAST) begin
        if (!ract_ff) begin
          if (!bitv) begin
            nxt_ract = 1'b1;
            nxt_ridx = 4'h0;
          end else begin
            nxt_rxc = 4'h0;
          end
        end else if (ridx_ff == rlast) begin
          nxt_ract = 1'b0;
          if (!bitv) begin
            nxt_fe = 1'b1;
          end
          if (!ninth_mode) begin
            push = 1'b1;
          end
        end else begin
          nxt_ridx = ridx_ff + 4'h1;
          nxt_rsh[ridx_ff] = bitv;
          if (CFG_I.mode == scc_pkg::MODE_U8 && ridx_ff == 4'h8) begin
            nxt_rsh[8] = bitv;
          end
          if (CFG_I.mode == scc_pkg::MODE_U7) begin
            nxt_rsh[8] = 1'b0;
          end
          if (ninth_mode && ridx_ff == rlast - 4'h1) begin
            push = 1'b1;
            pword = '{data: nxt_rsh[7:0], ninth: bitv};
          end
        end
      end
    end
    nxt_buf = buf_ff;
    nxt_cnt = cnt_ff;
    if (pop) begin
      nxt_buf[0] = buf_ff[1];
      nxt_cnt = cnt_ff - 2'h1;
    end
    if (push) begin
      // Second stage full: keep old word, drop new one
      if (nxt_cnt == 2'(scc_pkg::BUF_DEPTH)) begin
        nxt_oe = 1'b1;
      end else begin
        nxt_buf[nxt_cnt[0]] = pword;
        nxt_cnt = nxt_cnt + 2'h1;
        nxt_rirq = !(CFG_I.mode == scc_pkg::MODE_U9 && CFG_I.wakeup_en && !pword.ninth);
        if (CFG_I.parity_en && CFG_I.mode == scc_pkg::MODE_U7 &&
            pword.data[7] != par7(pword.data[6:0], CFG_I.parity_even)) begin
          nxt_pe = 1'b1;
        end
        if (CFG_I.parity_en && CFG_I.mode == scc_pkg::MODE_U8 &&
            pword.ninth != ~((^pword.data) ^ CFG_I.parity_even)) begin
          nxt_pe = 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sck_d_ff <= 1'b1;
      half_ff <= 1'b0;
      txc_ff <= 4'h0;
      tst_ff <= TX_IDLE;
      tsh_ff <= 10'h3FF;
      tbits_ff <= 4'h0;
      tout_ff <= 1'b1;
      tirq_ff <= 1'b0;
      rxc_ff <= 4'h0;
      smp_ff <= 3'h7;
      ract_ff <= 1'b0;
      ridx_ff <= 4'h0;
      rsh_ff <= 9'h000;
      pe_ff <= 1'b0;
      oe_ff <= 1'b0;
      fe_ff <= 1'b0;
      rirq_ff <= 1'b0;
      buf_ff[0] <= '0;
      buf_ff[1] <= '0;
      cnt_ff <= 2'h0;
    end else if (CE_I) begin
      sck_d_ff <= nxt_sck_d;
      half_ff <= nxt_half;
      txc_ff <= nxt_txc;
      tst_ff <= nxt_tst;
      tsh_ff <= nxt_tsh;
      tbits_ff <= nxt_tbits;
      tout_ff <= nxt_tout;
      tirq_ff <= nxt_tirq;
      rxc_ff <= nxt_rxc;
      smp_ff <= nxt_smp;
      ract_ff <= nxt_ract;
      ridx_ff <= nxt_ridx;
      rsh_ff <= nxt_rsh;
      pe_ff <= nxt_pe;
      oe_ff <= nxt_oe;
      fe_ff <= nxt_fe;
      rirq_ff <= nxt_rirq;
      buf_ff <= nxt_buf;
      cnt_ff <= nxt_cnt;
    end
  end

  assign SERIAL_OUT_PIN_O = tout_ff;
  assign SHIFT_CLOCK_PIN_O = half_ff;
  assign SHIFT_CLOCK_PIN_OE_O = 1'b0 | (!is_uart && !CFG_I.clk_dir_in);
  assign RX_VALID_O = cnt_ff != 2'h0;
  assign RX_WORD_O = buf_ff[0];
  assign PARITY_FAULT_FLAG_O = pe_ff;
  assign OVERRUN_FLAG_O = oe_ff;
  assign FRAMING_FLAG_O = fe_ff;
  assign RECEIVE_IRQ_O = rirq_ff;
  assign TRANSMIT_IRQ_O = tirq_ff;
  assign tbusy = tst_ff != TX_IDLE;

  // ****************************************
  // Checks
  // ****************************************
  AST_OVR_KEEPS: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && push && cnt_ff == 2'h2 && !pop |=> OVERRUN_FLAG_O && cnt_ff == 2'h2)
    else $error("overrun not flagged");
  AST_FLAG_CLR: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && FLAGS_READ_I && !push && !(ract_ff && rxc_ff == scc_pkg::SAMPLE_LAST)
    |=> !PARITY_FAULT_FLAG_O && !FRAMING_FLAG_O && !OVERRUN_FLAG_O)
    else $error("flags not cleared");
  AST_TX_DONE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    TRANSMIT_IRQ_O |-> SERIAL_OUT_PIN_O && !tbusy)
    else $error("transmit event without idle line");
  AST_HOLD: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    tst_ff == TX_HOLD && CTS_N_I |=> tst_ff == TX_HOLD || !CE_I)
    else $error("held frame started");
  AST_WAKE: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && push && CFG_I.mode == scc_pkg::MODE_U9 && CFG_I.wakeup_en && !pword.ninth
    |=> !RECEIVE_IRQ_O)
    else $error("wakeup filter failed");
  AST_START: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    CE_I && $rose(ract_ff) |-> $past(rxc_ff) == scc_pkg::SAMPLE_LAST && !$past(bitv))
    else $error("start accepted without low majority");
  AST_RXIRQ: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    RECEIVE_IRQ_O |-> RX_VALID_O)
    else $error("receive event with empty buffer");
  AST_IDLE_HI: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
    tst_ff == TX_IDLE && $past(tst_ff) == TX_IDLE |-> SERIAL_OUT_PIN_O)
    else $error("line not idle high");
endmodule // scc_core

// ---- rtl/scc_pkg.sv ----
// Contract
// - Outgoing shift clock mode: base clock is generator tick halved.
// - Incoming shift clock mode: base clock from chosen edge of that clock.
// - UART base clock from generator, system clock, timer match or clock pin.
// - Sixteen base pulses per bit; samples at counts 6, 7, 8; majority wins.
// - Start bit accepted only when at least two of three samples are low.
// - Synchronous input sampled on the selected edge of the shift clock.
// - First-stage shifter hands character to readable buffer, raising receive event.
// - New character with both buffer stages unread sets overrun, drops new data, keeps old.
// - Received ninth bit holds parity in 8-bit mode, data MSB in 9-bit.
// - Nine-bit mode with wakeup raises receive event only when ninth bit set.
// - Transmit counter gives one bit tick per sixteen base pulses.
// - Synchronous output shifted one bit per selected shift clock edge.
// - UART transmission starts at the next bit tick after a write.
// - Handshake on: clear-to-send high holds new frames; transmit event still raised.
// - Held frame starts on bit tick after clear-to-send falls; running frame finishes.
// - Parity only in 7-bit and 8-bit UART modes, even or odd selectable.
// - Parity computed at write, put in bit 7 or ninth bit.
// - Received parity checked in the same cycle as the buffer transfer; mismatch sets parity flag.
// - Stop bit sampled three times; majority low sets framing flag.
// - Ninth-bit modes signal receive and overrun at ninth bit centre, else stop.
// - Clock source codes: 00 timer, 01 generator, 10 system, 11 pin.
// - Mode codes: 00 synchronous, 01 7-bit, 10 8-bit, 11 9-bit.
// - Reading the error flags clears all three at once.
package scc_pkg;
  localparam logic [1:0] SRC_TIMER = 2'h0;
  localparam logic [1:0] SRC_BRG = 2'h1;
  localparam logic [1:0] SRC_SYS = 2'h2;
  localparam logic [1:0] SRC_PIN = 2'h3;
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_U7 = 2'h1;
  localparam logic [1:0] MODE_U8 = 2'h2;
  localparam logic [1:0] MODE_U9 = 2'h3;
  localparam logic [3:0] SAMPLE_FIRST = 4'h6;
  localparam logic [3:0] SAMPLE_MID = 4'h7;
  localparam logic [3:0] SAMPLE_LAST = 4'h8;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] SYNC_BITS = 4'h8;
  localparam logic [3:0] BUF_DEPTH = 4'h2;
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] clk_src;
    logic clk_dir_in;
    logic edge_fall;
    logic parity_en;
    logic parity_even;
    logic wakeup_en;
    logic handshake_en;
    logic receive_en;
  } scc_cfg_t;
  typedef struct packed {
    logic [7:0] data;
    logic ninth;
  } scc_word_t;
endpackage

// ---- tb/scc_core_tb.sv ----
`timescale 1ns/1ns
module scc_core_tb;
  logic clk, rst_n, tx_valid, tx_ninth, rx_ready, flags_read, brg, tmr, late;
  logic tx_ready, rx_valid, parity_fault_flag, overrun_flag, framing_flag, rx_irq, tx_irq, txd, rxd, cts_n;
  logic [7:0] tx_data;
  logic [8:0] img;
  scc_pkg::scc_cfg_t cfg;
  scc_pkg::scc_word_t rx_word;
  int err_total, checks, seed, n_rx, n_tx, n0;
  time t_irq, t_end;
  // ****
  // Core and far side
  // ****
  // Clock enable tied high: gating is not exercised here
  scc_core uut (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .CFG_I(cfg), .BRG_TICK_I(brg),
    .TIMER_MATCH_I(tmr), .TX_VALID_I(tx_valid), .TX_READY_O(tx_ready), .TX_DATA_I(tx_data),
    .TX_NINTH_I(tx_ninth), .RX_VALID_O(rx_valid), .RX_READY_I(rx_ready), .RX_WORD_O(rx_word),
    .FLAGS_READ_I(flags_read), .PARITY_FAULT_FLAG_O(parity_fault_flag), .OVERRUN_FLAG_O(overrun_flag),
    .FRAMING_FLAG_O(framing_flag), .RECEIVE_IRQ_O(rx_irq), .TRANSMIT_IRQ_O(tx_irq),
    .SERIAL_IN_PIN_I(rxd), .SERIAL_OUT_PIN_O(txd), .CTS_N_I(cts_n),
    .SHIFT_CLOCK_PIN_I(1'b0), .SHIFT_CLOCK_PIN_O(), .SHIFT_CLOCK_PIN_OE_O()
  );
  scc_remote rem (.clk_i(clk), .txd_i(txd), .rxd_o(rxd), .cts_n_o(cts_n));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk) begin
    brg = 1'($random(seed));
    tmr = 1'($random(seed));
  end
  always @(posedge clk) begin
    if (rx_irq === 1'b1) begin
      n_rx++;
      t_irq = $time;
    end
    if (tx_irq === 1'b1) n_tx++;
  end
  // ****
  // Helpers
  // ****
  function automatic logic par(input logic [7:0] d, input int n, input logic ev);
    logic p;
    p = ~ev;
    for (int i = 0; i < n; i++) p ^= d[i];
    return p;
  endfunction
  function automatic int nb(input logic [1:0] m, input logic pe);
    return (m == scc_pkg::MODE_U9) ? 9 : 32'(m) + 6 + 32'(pe);
  endfunction
  // Line image LSB first; parity ignored in nine-bit mode
  function automatic logic [8:0] image(input logic [1:0] m, input logic pe, input logic ev,
                                       input logic [7:0] d, input logic n9);
    if (m == scc_pkg::MODE_U9) return {n9, d};
    if (m == scc_pkg::MODE_U8) return {pe & par(d, 8, ev), d};
    return {1'b0, pe & par(d, 7, ev), d[6:0]};
  endfunction
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic fail();
    err_total++;
    print_verdict();
  endtask
  task automatic read_flags();
    flags_read = 1'b1;
    @(negedge clk);
    flags_read = 1'b0;
    @(negedge clk);
  endtask
  task automatic tx_one(input logic [1:0] m, input logic pe, input logic ev, input logic hold);
    logic [8:0] got;
    logic stop, ok, idle;
    int w;
    n0 = n_tx;
    w = 0;
    cfg.mode = m;
    cfg.parity_en = pe;
    cfg.parity_even = ev;
    while (tx_ready !== 1'b1 && w < 3000) begin
      @(negedge clk);
      w++;
    end
    if (w == 3000) fail();
    @(negedge clk);
    tx_data = 8'($random(seed));
    tx_ninth = 1'($random(seed));
    tx_valid = 1'b1;
    img = image(m, pe, ev, tx_data, tx_ninth);
    @(negedge clk);
    tx_valid = 1'b0;
    if (hold) begin
      idle = 1'b1;
      repeat (64) begin
        @(negedge clk);
        idle &= txd;
      end
      check("held line", 9'h001, {8'h00, idle});
      rem.set_cts(1'b0);
    end
    rem.take(nb(m, pe), got, stop, ok);
    check("tx start", 9'h001, {8'h00, ok});
    if (!ok) fail();
    check("tx frame", img, got);
    check("tx stop", 9'h001, {8'h00, stop});
    repeat (24) @(negedge clk);
    check("tx event", 9'(n0 + 1), 9'(n_tx));
  endtask
  task automatic pop(input logic [8:0] exp, input int n);
    logic [8:0] mk;
    int w;
    mk = 9'((1 << n) - 1);
    w = 0;
    while (rx_valid !== 1'b1 && w < 400) begin
      @(negedge clk);
      w++;
    end
    if (w == 400) fail();
    check("rx word", exp & mk, {rx_word.ninth, rx_word.data} & mk);
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
  endtask
  // ****
  // Scenarios
  // ****
  initial begin
    seed = 27;
    rst_n = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    tx_ninth = 1'b0;
    rx_ready = 1'b0;
    flags_read = 1'b0;
    brg = 1'b0;
    tmr = 1'b0;
    cfg = '0;
    cfg.clk_src = scc_pkg::SRC_SYS;
    cfg.receive_en = 1'b1;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check("reset outputs", 9'h030, {3'h0, txd, tx_ready, rx_valid, parity_fault_flag, overrun_flag, framing_flag});
    for (int k = 0; k < 12; k++) tx_one(2'(k % 3 + 1), 1'(k / 3), 1'(k / 6), 1'b0);
    cfg.handshake_en = 1'b1;
    rem.set_cts(1'b1);
    tx_one(scc_pkg::MODE_U8, 1'b1, 1'b0, 1'b1);
    rem.dip(2);
    repeat (200) @(negedge clk);
    check("false start", 9'h000, {8'h00, rx_valid});
    for (int k = 0; k < 12; k++) begin
      cfg.mode = 2'(k % 3 + 1);
      cfg.parity_en = 1'(k / 3);
      cfg.parity_even = 1'(k / 6);
      tx_data = 8'($random(seed));
      tx_ninth = 1'($random(seed));
      img = image(cfg.mode, cfg.parity_en, cfg.parity_even, tx_data, tx_ninth);
      rem.send(img, nb(cfg.mode, cfg.parity_en), 1'b1, 1'(k));
      t_end = $time;
      late = (t_end - t_irq) < 64;
      n0 = (cfg.mode == scc_pkg::MODE_U7 || (cfg.mode == scc_pkg::MODE_U8 && !cfg.parity_en));
      check("event timing", 9'(n0), {8'h00, late});
      pop(img, nb(cfg.mode, cfg.parity_en));
      check("parity flag", 9'h000, {8'h00, parity_fault_flag});
    end
    check("rx events", 9'h00C, 9'(n_rx));
    for (int j = 0; j < 2; j++) begin
      cfg.mode = 2'(2 - j);
      cfg.parity_en = 1'b1;
      img = image(cfg.mode, 1'b1, cfg.parity_even, 8'h5A, 1'b0) ^ (j ? 9'h080 : 9'h100);
      rem.send(img, nb(cfg.mode, 1'b1), 1'b1, 1'b0);
      pop(img, nb(cfg.mode, 1'b1));
      check("parity flag", 9'h001, {8'h00, parity_fault_flag});
      read_flags();
      check("flags cleared", 9'h000, {6'h00, parity_fault_flag, overrun_flag, framing_flag});
    end
    cfg.mode = scc_pkg::MODE_U9;
    for (int j = 0; j < 3; j++) rem.send(9'h0C3 + 9'(j), 9, 1'b1, 1'b0);
    check("overrun flag", 9'h001, {8'h00, overrun_flag});
    pop(9'h0C3, 9);
    pop(9'h0C4, 9);
    check("third dropped", 9'h000, {8'h00, rx_valid});
    cfg.receive_en = 1'b0;
    read_flags();
    cfg.receive_en = 1'b1;
    rem.send(9'h1A5, 9, 1'b0, 1'b0);
    pop(9'h1A5, 9);
    check("framing flag", 9'h001, {8'h00, framing_flag});
    // A low stop can look like a new start, so drain whatever it left
    repeat (300) @(negedge clk);
    rx_ready = 1'b1;
    repeat (3) @(negedge clk);
    rx_ready = 1'b0;
    read_flags();
    cfg.wakeup_en = 1'b1;
    n0 = n_rx;
    rem.send(9'h011, 9, 1'b1, 1'b0);
    rem.send(9'h122, 9, 1'b1, 1'b0);
    check("wakeup events", 9'(n0 + 1), 9'(n_rx));
    print_verdict();
  end
endmodule // scc_core_tb

// ---- tb/scc_remote.sv ----
`timescale 1ns/1ns
module scc_remote (
  // Clock
  input wire logic clk_i,
  // Line pins
  input wire logic txd_i,
  output logic rxd_o,
  output logic cts_n_o
);
  // ****
  // Far side UART
  // ****
  // Line idles high, as a pulled-up line would
  initial begin
    rxd_o = 1'b1;
    cts_n_o = 1'b0;
  end
  // Start, n bits LSB first, stop; gl flips the centre sample of bit 0
  task automatic send(input logic [8:0] b, input int n, input logic stop, input logic gl);
    for (int i = -1; i <= n; i++) begin
      for (int k = 0; k < 16; k++) begin
        @(negedge clk_i);
        rxd_o = ((i < 0) ? 1'b0 : (i < n) ? b[i] : stop) ^ (gl && i == 0 && k == 7);
      end
    end
    @(negedge clk_i);
    rxd_o = 1'b1;
  endtask
  // Short low pulse, too short to be a start bit
  task automatic dip(input int len);
    @(negedge clk_i);
    rxd_o = 1'b0;
    repeat (len) @(negedge clk_i);
    rxd_o = 1'b1;
  endtask
  task automatic set_cts(input logic v);
    @(negedge clk_i);
    cts_n_o = v;
  endtask
  // Captures one frame at bit centres; bound keeps a dead line from hanging
  task automatic take(input int n, output logic [8:0] b, output logic stop, output logic ok);
    int w;
    b = 9'h000;
    stop = 1'b0;
    w = 0;
    while (txd_i !== 1'b0 && w < 28) begin
      @(negedge clk_i);
      w++;
    end
    ok = (w < 28);
    repeat (8) @(negedge clk_i);
    for (int i = 0; i < n; i++) begin
      repeat (16) @(negedge clk_i);
      b[i] = txd_i;
    end
    repeat (16) @(negedge clk_i);
    stop = txd_i;
  endtask
endmodule // scc_remote
